// [bldc_commutation_sequencer.sv]
// six-step sensorless commutation sequencer with serial configuration
// assumes all pin inputs synchronous to clock_in; comparator results arrive
// as digital levels (floating phase above neutral tap = 1)
//
// Behaviour
// - six states, one source, one sink, one off
// - fixed phase pattern per sequencer state
// - sense back-EMF only on floating phase
// - outputs off at start; after reset, run enables them in state one
// - only correct-polarity crossings drive commutation
// - zero-cross flag toggles, selectable to diagnostics
// - startup timer expiry forces next state
// - each commutation restarts startup timer
// - first delay timer up high, down double
// - second timer on opposite flag phase
// - commutation restarts blanking and watchdog
// - outside step mode, no crossing before watchdog forces commutation
// - brake pin turns on all sinks
// - serial brake bit brakes the same
// - reset clears configuration, enters sleep
// - diagnostic output picks one of four
// - reference clock drives speed reference counter
// - sector input alternative rev_pulse source
// - shift 24 bits on serial clock, apply on strobe rise
// - select codes rev_pulse, thermal, sync, zero-cross
`timescale 1ns/10ps
`default_nettype none

module bldc_commutation_sequencer
#(
    parameter int unsigned STARTUP_LIMIT  = commutation_pkg::STARTUP_CYCLES,
    parameter int unsigned WATCHDOG_LIMIT = commutation_pkg::WATCHDOG_CYCLES
)
(
    input  wire logic                           clock_in,        // 100 MHz reference
    input  wire logic                           reset_n_in,      // async, active low
    input  wire logic                           brake_n_in,      // brake pin, active low
    input  wire logic                           bemf_a_in,       // phase a above neutral
    input  wire logic                           bemf_b_in,       // phase b above neutral
    input  wire logic                           bemf_c_in,       // phase c above neutral
    input  wire logic                           sector_in,       // external rev_pulse pulses
    input  wire logic                           thermal_in,      // thermal shutdown flag
    input  wire logic                           ser_clk_in,      // serial clock level
    input  wire logic                           ser_data_in,     // serial data level
    input  wire logic                           ser_strobe_n_in, // word strobe, active low
    output logic                                phase_a_drive_out, // phase a driven
    output logic                                phase_b_drive_out, // phase b driven
    output logic                                phase_c_drive_out, // phase c driven
    output commutation_pkg::phase_drive_t       drive_out,       // bridge gate controls
    output logic                                diag_out,        // diagnostic mux
    output logic [2:0]                          state_out        // sequencer state 0..5
);

    // --------------------------------------------------------------
    // serial port
    // --------------------------------------------------------------
    logic [23:0] shift_reg, next_shift_reg;
    logic [23:0] config_word, next_config_word;
    logic        ser_clk_q, strobe_q;
    logic        next_ser_clk_q, next_strobe_q;

    // edges seen on sampled levels; clock only counts while strobe is low
    always_comb
    begin
        next_ser_clk_q   = ser_clk_in;
        next_strobe_q    = ser_strobe_n_in;
        next_shift_reg   = shift_reg;
        next_config_word = config_word;
        if (!ser_strobe_n_in && ser_clk_in && !ser_clk_q)
            next_shift_reg = {shift_reg[22:0], ser_data_in};
        if (ser_strobe_n_in && !strobe_q)
            next_config_word = shift_reg;
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            shift_reg   <= commutation_pkg::WORD_RESET;
            config_word <= commutation_pkg::WORD_RESET;
            ser_clk_q   <= 1'b0;
            strobe_q    <= 1'b1;
        end
        else
        begin
            shift_reg   <= next_shift_reg;
            config_word <= next_config_word;
            ser_clk_q   <= next_ser_clk_q;
            strobe_q    <= next_strobe_q;
        end
    end

    logic       run_mode, step_mode, sector_mode;
    logic [1:0] diag_sel;
    assign run_mode    = config_word[commutation_pkg::BIT_RUN];
    assign step_mode   = config_word[commutation_pkg::BIT_STEP];
    assign sector_mode = config_word[commutation_pkg::BIT_SECTOR];
    assign diag_sel    = {config_word[commutation_pkg::BIT_DIAG_A],
                          config_word[commutation_pkg::BIT_DIAG_B]};

    // --------------------------------------------------------------
    // sequencer and back-EMF qualification
    // --------------------------------------------------------------
    commutation_pkg::seq_state_t state, next_state;
    logic        zero_cross_toggle, next_zero_cross_toggle;
    logic        brake_latch, next_brake_latch;
    logic        bemf_prev, next_bemf_prev;
    logic        seen_cross, next_seen_cross;
    logic        float_bemf, rising_expected, crossing, commutate;
    logic        startup_fire, delay_fire, watchdog_fire, blanking;

    // floating phase and expected edge direction per state
    always_comb
    begin
        float_bemf      = 1'b0;
        rising_expected = 1'b0;
        case (state)
            commutation_pkg::SEQ_1: begin float_bemf = bemf_c_in; rising_expected = 1'b1; end
            commutation_pkg::SEQ_2: begin float_bemf = bemf_a_in; rising_expected = 1'b0; end
            commutation_pkg::SEQ_3: begin float_bemf = bemf_b_in; rising_expected = 1'b1; end
            commutation_pkg::SEQ_4: begin float_bemf = bemf_c_in; rising_expected = 1'b0; end
            commutation_pkg::SEQ_5: begin float_bemf = bemf_a_in; rising_expected = 1'b1; end
            commutation_pkg::SEQ_6: begin float_bemf = bemf_b_in; rising_expected = 1'b0; end
            default:                begin float_bemf = 1'b0;      rising_expected = 1'b0; end
        endcase
    end

    // blanked comparator ignored; only the expected direction counts, once per state
    assign crossing = !blanking && !step_mode && !seen_cross
                      && (float_bemf != bemf_prev)
                      && (float_bemf == rising_expected);
    assign commutate = run_mode && (startup_fire || delay_fire || watchdog_fire);

    always_comb
    begin
        next_state             = state;
        next_zero_cross_toggle = zero_cross_toggle;
        next_bemf_prev         = float_bemf;
        next_seen_cross        = seen_cross;
        next_brake_latch       = brake_latch || !brake_n_in
                                 || config_word[commutation_pkg::BIT_BRAKE];
        if (crossing)
        begin
            next_zero_cross_toggle = !zero_cross_toggle;
            next_seen_cross        = 1'b1;
        end
        if (commutate)
        begin
            // n to n+1, wrapping six back to one
            case (state)
                commutation_pkg::SEQ_1: next_state = commutation_pkg::SEQ_2;
                commutation_pkg::SEQ_2: next_state = commutation_pkg::SEQ_3;
                commutation_pkg::SEQ_3: next_state = commutation_pkg::SEQ_4;
                commutation_pkg::SEQ_4: next_state = commutation_pkg::SEQ_5;
                commutation_pkg::SEQ_5: next_state = commutation_pkg::SEQ_6;
                default:                next_state = commutation_pkg::SEQ_1;
            endcase
            next_seen_cross = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state             <= commutation_pkg::SEQ_1;
            zero_cross_toggle <= 1'b0;
            bemf_prev         <= 1'b0;
            seen_cross        <= 1'b0;
            brake_latch       <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            zero_cross_toggle <= next_zero_cross_toggle;
            bemf_prev         <= next_bemf_prev;
            seen_cross        <= next_seen_cross;
            brake_latch       <= next_brake_latch;
        end
    end

    // --------------------------------------------------------------
    // timers
    // --------------------------------------------------------------
    logic [23:0] startup_timer, next_startup_timer;
    logic [23:0] blank_watchdog_timer, next_blank_watchdog_timer;
    logic [23:0] delay_timer_one, next_delay_timer_one;
    logic [23:0] delay_timer_two, next_delay_timer_two;
    logic        flag_q, next_flag_q;
    logic        down_one, next_down_one, down_two, next_down_two;

    assign startup_fire  = startup_timer >= 24'(STARTUP_LIMIT - 1);
    assign blanking      = blank_watchdog_timer < 24'(commutation_pkg::BLANK_CYCLES);
    assign watchdog_fire = !step_mode && !seen_cross
                           && blank_watchdog_timer >= 24'(WATCHDOG_LIMIT - 1);
    // a trim threshold fires the down-count slightly before half period
    assign delay_fire    = !step_mode
                           && ((down_one && delay_timer_one <= 24'(commutation_pkg::DELAY_TRIM))
                           ||  (down_two && delay_timer_two <= 24'(commutation_pkg::DELAY_TRIM)));

    // accumulate on one flag level, drain at twice the rate on the other
    always_comb
    begin
        next_flag_q               = zero_cross_toggle;
        next_startup_timer        = startup_timer + 24'h000001;
        next_blank_watchdog_timer = blank_watchdog_timer;
        next_delay_timer_one      = delay_timer_one;
        next_delay_timer_two      = delay_timer_two;
        next_down_one             = down_one;
        next_down_two             = down_two;
        if (blank_watchdog_timer != 24'hffffff)
            next_blank_watchdog_timer = blank_watchdog_timer + 24'h000001;
        // a delay commutation ends the down-count, but a flag edge in the
        // same cycle re-arms a timer below, so that half period is not lost
        if (commutate && delay_fire)
        begin
            next_down_one = 1'b0;
            next_down_two = 1'b0;
        end
        if (zero_cross_toggle && !flag_q)
        begin
            next_delay_timer_one = 24'h000000;
            next_down_one        = 1'b0;
            next_down_two        = 1'b1;
        end
        else if (!zero_cross_toggle && flag_q)
        begin
            next_delay_timer_two = 24'h000000;
            next_down_two        = 1'b0;
            next_down_one        = 1'b1;
        end
        else
        begin
            if (zero_cross_toggle && delay_timer_one != 24'hffffff)
                next_delay_timer_one = delay_timer_one + 24'h000001;
            if (!zero_cross_toggle && delay_timer_two != 24'hffffff)
                next_delay_timer_two = delay_timer_two + 24'h000001;
            if (down_one)
                next_delay_timer_one = (delay_timer_one > 24'h000002)
                                       ? delay_timer_one - 24'h000002 : 24'h000000;
            if (down_two)
                next_delay_timer_two = (delay_timer_two > 24'h000002)
                                       ? delay_timer_two - 24'h000002 : 24'h000000;
        end
        if (commutate)
        begin
            next_startup_timer        = 24'h000000;
            next_blank_watchdog_timer = 24'h000000;
        end
        if (!run_mode)
            next_startup_timer = 24'h000000;
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            startup_timer        <= 24'h000000;
            blank_watchdog_timer <= 24'h000000;
            delay_timer_one      <= 24'h000000;
            delay_timer_two      <= 24'h000000;
            flag_q               <= 1'b0;
            down_one             <= 1'b0;
            down_two             <= 1'b0;
        end
        else
        begin
            startup_timer        <= next_startup_timer;
            blank_watchdog_timer <= next_blank_watchdog_timer;
            delay_timer_one      <= next_delay_timer_one;
            delay_timer_two      <= next_delay_timer_two;
            flag_q               <= next_flag_q;
            down_one             <= next_down_one;
            down_two             <= next_down_two;
        end
    end

    // --------------------------------------------------------------
    // speed reference counter and rev_pulse selection
    // --------------------------------------------------------------
    logic [17:0] ref_count, next_ref_count;
    logic        sector_q, next_sector_q, rev_pulse, next_rev_pulse;
    logic        ref_active, next_ref_active;
    logic [17:0] ref_total;
    logic        rev_pulse_edge;

    // count field is active low; bit weights 16 upward
    assign ref_total = {~config_word[commutation_pkg::BIT_REF_LO +: commutation_pkg::REF_BITS],
                        4'h0};
    assign rev_pulse_edge = sector_mode ? (sector_in && !sector_q)
                                   : (zero_cross_toggle && !flag_q);

    always_comb
    begin
        next_sector_q   = sector_in;
        next_rev_pulse  = rev_pulse;
        next_ref_count  = ref_count;
        next_ref_active = ref_active;
        if (rev_pulse_edge)
            next_rev_pulse = !rev_pulse;
        if (rev_pulse_edge && !rev_pulse)
        begin
            next_ref_count  = 18'h00000;
            next_ref_active = 1'b1;
        end
        else if (ref_active)
        begin
            next_ref_count = ref_count + 18'h00001;
            if (ref_count + 18'h00001 >= ref_total)
                next_ref_active = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ref_count  <= 18'h00000;
            sector_q   <= 1'b0;
            rev_pulse  <= 1'b0;
            ref_active <= 1'b0;
        end
        else
        begin
            ref_count  <= next_ref_count;
            sector_q   <= next_sector_q;
            rev_pulse  <= next_rev_pulse;
            ref_active <= next_ref_active;
        end
    end

    // --------------------------------------------------------------
    // output drive and diagnostic mux, all registered
    // --------------------------------------------------------------
    commutation_pkg::phase_drive_t next_drive;
    logic next_diag;
    localparam commutation_pkg::half_bridge_t HI = 2'b10;
    localparam commutation_pkg::half_bridge_t LO = 2'b01;
    localparam commutation_pkg::half_bridge_t HZ = 2'b00;

    always_comb
    begin
        case (state)
            commutation_pkg::SEQ_1: next_drive = {HI, LO, HZ};
            commutation_pkg::SEQ_2: next_drive = {HZ, LO, HI};
            commutation_pkg::SEQ_3: next_drive = {LO, HZ, HI};
            commutation_pkg::SEQ_4: next_drive = {LO, HI, HZ};
            commutation_pkg::SEQ_5: next_drive = {HZ, HI, LO};
            commutation_pkg::SEQ_6: next_drive = {HI, HZ, LO};
            default:                next_drive = {HZ, HZ, HZ};
        endcase
        if (next_brake_latch)
            next_drive = {LO, LO, LO};
        else if (!run_mode)
            next_drive = {HZ, HZ, HZ};
        case (diag_sel)
            commutation_pkg::DIAG_REV_PULSE:    next_diag = rev_pulse;
            commutation_pkg::DIAG_THERMAL: next_diag = thermal_in;
            commutation_pkg::DIAG_SYNC:    next_diag = ref_active;
            commutation_pkg::DIAG_ZERO:    next_diag = zero_cross_toggle;
            default:                       next_diag = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            drive_out         <= '0;
            diag_out          <= 1'b0;
            state_out         <= 3'h0;
            phase_a_drive_out <= 1'b0;
            phase_b_drive_out <= 1'b0;
            phase_c_drive_out <= 1'b0;
        end
        else
        begin
            drive_out         <= next_drive;
            diag_out          <= next_diag;
            state_out         <= 3'(next_state);
            phase_a_drive_out <= next_drive.a.source || next_drive.a.sink;
            phase_b_drive_out <= next_drive.b.source || next_drive.b.sink;
            phase_c_drive_out <= next_drive.c.source || next_drive.c.sink;
        end
    end

endmodule : bldc_commutation_sequencer

`default_nettype wire

// [commutation_pkg.sv]
// package for the six-step commutation sequencer
// assumes a 100 MHz system clock and synchronous pin inputs
package commutation_pkg;

    // ----------------------------------------
    // timing, set in microseconds and converted to reference clock cycles
    // ----------------------------------------
    localparam int unsigned CLOCK_NS          = 10;
    localparam int unsigned STARTUP_TIME_US   = 2000;
    localparam int unsigned STARTUP_CYCLES    = STARTUP_TIME_US * 1000 / CLOCK_NS;
    localparam int unsigned BLANK_TIME_US     = 20;
    localparam int unsigned BLANK_CYCLES      = BLANK_TIME_US * 1000 / CLOCK_NS;
    localparam int unsigned WATCHDOG_TIME_US  = 1000;
    localparam int unsigned WATCHDOG_CYCLES   = WATCHDOG_TIME_US * 1000 / CLOCK_NS;
    localparam int unsigned TIMER_WIDTH       = 24;
    localparam int unsigned DELAY_TRIM        = 2;  // fires a little before midpoint

    // ----------------------------------------
    // serial word layout
    // ----------------------------------------
    localparam int unsigned WORD_BITS         = 24;
    localparam int unsigned BIT_RUN           = 0;
    localparam int unsigned BIT_STEP          = 1;
    localparam int unsigned BIT_BRAKE         = 2;
    localparam int unsigned BIT_CURLIM_LO     = 3;
    localparam int unsigned BIT_REF_LO        = 5;
    localparam int unsigned REF_BITS          = 14;
    localparam int unsigned BIT_SECTOR        = 19;
    localparam int unsigned BIT_POLES_LO      = 20;
    localparam int unsigned BIT_DIAG_A        = 22;
    localparam int unsigned BIT_DIAG_B        = 23;
    localparam logic [23:0] WORD_RESET        = 24'h000000;
    localparam int unsigned REF_SHIFT         = 4;  // lsb of count field weighs 16

    // diagnostic select, first bit shifted in is the low select bit
    localparam logic [1:0] DIAG_REV_PULSE    = 2'h0;
    localparam logic [1:0] DIAG_THERMAL = 2'h1;
    localparam logic [1:0] DIAG_SYNC    = 2'h2;
    localparam logic [1:0] DIAG_ZERO    = 2'h3;

    typedef enum logic [2:0] {
        SEQ_1, SEQ_2, SEQ_3, SEQ_4, SEQ_5, SEQ_6
    } seq_state_t;

    // one half-bridge: source on, sink on (both off means high impedance)
    typedef struct packed {
        logic source;
        logic sink;
    } half_bridge_t;

    typedef struct packed {
        half_bridge_t a;
        half_bridge_t b;
        half_bridge_t c;
    } phase_drive_t;

endpackage : commutation_pkg

// [motor_model.sv]
// windings and neutral-tap comparator seen from the sequencer
// assumes drive_in is the registered bridge control word
`timescale 1ns/10ps
`default_nettype none
module motor_model #(parameter int DLY = 2200)
(
    input  wire commutation_pkg::phase_drive_t drive_in, // bridge controls
    input  wire logic clock_in,                          // system clock
    input  wire logic stall_in,                          // rotor held
    output logic [2:0] bemf_out                          // {a,b,c} above tap
);
    // ------------------------------------------------------------
    // rotor angle since the last bridge change
    // ------------------------------------------------------------
    logic [5:0] last = '0;
    int         cnt  = 0;
    logic [2:0] src;
    logic [2:0] snk;
    always @(posedge clock_in)
    begin
        last <= drive_in;
        cnt  <= (drive_in != last) ? 0 : (cnt < DLY ? cnt + 1 : cnt);
    end
    // floating phase rests on the wrong side until it crosses; stall never crosses
    always_comb
    begin
        src = {drive_in.a.source, drive_in.b.source, drive_in.c.source};
        snk = {drive_in.a.sink, drive_in.b.sink, drive_in.c.sink};
        for (int i = 0; i < 3; i++)
            bemf_out[i] = (src[i] | snk[i]) ? src[i]
                          : snk[(i + 1) % 3] ^ ~(cnt >= DLY && !stall_in);
    end
endmodule : motor_model
`default_nettype wire

// [seq_chk.sv]
// port checker for the commutation sequencer
// assumes drive_out lags state_out by one clock
`timescale 1ns/10ps
`default_nettype none
module seq_chk #(parameter int unsigned STARTUP_LIMIT = 200, WATCHDOG_LIMIT = 5000)
(
    input wire logic clock_in, reset_n_in, brake_n_in, bemf_a_in, bemf_b_in, bemf_c_in,
    input wire logic sector_in, thermal_in, ser_clk_in, ser_data_in, ser_strobe_n_in,
    input wire logic phase_a_drive_out, phase_b_drive_out, phase_c_drive_out, diag_out,
    input wire commutation_pkg::phase_drive_t drive_out,
    input wire logic [2:0] state_out
);
    // ------------------------------------------------------------
    // helpers: bridge halves and cycles held in one state
    // ------------------------------------------------------------
    localparam logic [5:0] ENC [6] = '{6'h24, 6'h06, 6'h12, 6'h18, 6'h09, 6'h21};
    localparam int BLANK = commutation_pkg::BLANK_CYCLES;
    logic [2:0]  src;
    logic [2:0]  snk;
    logic [2:0]  prev_st;
    int unsigned held;
    assign src = {drive_out[5], drive_out[3], drive_out[1]};
    assign snk = {drive_out[4], drive_out[2], drive_out[0]};
    // idle or braked bridges restart the count, so sleep never trips the cap
    always_ff @(posedge clock_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            prev_st <= '0;
            held    <= 0;
        end
        else
        begin
            prev_st <= state_out;
            held    <= (state_out != prev_st || src == '0) ? 0 : held + 1;
        end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    property p_one; src != '0 |-> $onehot(src) && $onehot(snk); endproperty
    a_one: assert property (p_one) else $error("bridge not one source one sink");
    property p_enc; src != '0 |-> drive_out == ENC[$past(state_out)]; endproperty
    a_enc: assert property (p_enc) else $error("bridge pattern wrong for state");
    property p_ord; state_out != prev_st |->
        state_out == (prev_st == 3'h5 ? 3'h0 : prev_st + 3'h1); endproperty
    a_ord: assert property (p_ord) else $error("state skipped");
    property p_blank; state_out != prev_st && src != '0 |-> held >= BLANK - 4; endproperty
    a_blank: assert property (p_blank) else $error("commutation inside blanking");
    property p_cap; src != '0 |-> held <= STARTUP_LIMIT + 4; endproperty
    a_cap: assert property (p_cap) else $error("startup timer never fired");
    property p_brake; !brake_n_in |-> ##[1:2] drive_out == 6'h15; endproperty
    a_brake: assert property (p_brake) else $error("brake pin did not brake");
    property p_sleep; !$past(reset_n_in) |-> drive_out == 6'h00; endproperty
    a_sleep: assert property (p_sleep) else $error("outputs live after reset");
    property p_pins;
        {phase_a_drive_out, phase_b_drive_out, phase_c_drive_out} == (src | snk); endproperty
    a_pins: assert property (p_pins) else $error("phase enables disagree");
    c_wrap: cover property (state_out == 3'h0 && prev_st == 3'h5);
    c_brake: cover property (drive_out == 6'h15);
    c_diag: cover property ($changed(diag_out));
endmodule : seq_chk
bind bldc_commutation_sequencer seq_chk
    #(.STARTUP_LIMIT(STARTUP_LIMIT), .WATCHDOG_LIMIT(WATCHDOG_LIMIT)) chk_u
    (.clock_in(clock_in), .reset_n_in(reset_n_in), .brake_n_in(brake_n_in),
     .bemf_a_in(bemf_a_in), .bemf_b_in(bemf_b_in), .bemf_c_in(bemf_c_in),
     .sector_in(sector_in), .thermal_in(thermal_in), .ser_clk_in(ser_clk_in),
     .ser_data_in(ser_data_in), .ser_strobe_n_in(ser_strobe_n_in),
     .phase_a_drive_out(phase_a_drive_out), .phase_b_drive_out(phase_b_drive_out),
     .phase_c_drive_out(phase_c_drive_out), .diag_out(diag_out),
     .drive_out(drive_out), .state_out(state_out));
`default_nettype wire

// [tb.sv]
// testbench for the commutation sequencer
// assumes motor_model on the phases and seq_chk bound to the design
`timescale 1ns/10ps
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // shortened timers keep the run near 73k cycles
    // ------------------------------------------------------------
    localparam int SL = 8000;
    localparam int WL = 5000;
    logic clk = 0, rst_n = 0, brk_n = 1, sec = 0, therm = 0, stall = 0;
    logic sck = 0, sda = 0, scs_n = 1, pa, pb, pc, diag;
    logic [2:0] bemf, st;
    commutation_pkg::phase_drive_t drv;
    int fail_count = 0, check_count = 0, g, tg;
    always #5 clk = ~clk;
    bldc_commutation_sequencer #(.STARTUP_LIMIT(SL), .WATCHDOG_LIMIT(WL)) dut_u (.clock_in(clk),
        .reset_n_in(rst_n), .brake_n_in(brk_n), .bemf_a_in(bemf[2]), .bemf_b_in(bemf[1]),
        .bemf_c_in(bemf[0]), .sector_in(sec), .thermal_in(therm), .ser_clk_in(sck),
        .ser_data_in(sda), .ser_strobe_n_in(scs_n), .phase_a_drive_out(pa), .phase_b_drive_out(pb),
        .phase_c_drive_out(pc), .drive_out(drv), .diag_out(diag), .state_out(st));
    motor_model motor_u (.clock_in(clk), .drive_in(drv), .stall_in(stall), .bemf_out(bemf));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // 24 bits, first bit is bit 23; serial clock high two cycles as required
    task automatic send(input logic [23:0] w);
        scs_n = 0;
        for (int i = 23; i >= 0; i--)
        begin
            sda = w[i];
            cyc(2);
            sck = 1;
            cyc(2);
            sck = 0;
        end
        scs_n = 1;
        cyc(3);
    endtask : send
    function automatic logic [23:0] word(input logic run, step, brk, input logic [1:0] sel);
        word = {sel[0], sel[1], 19'h0, brk, step, run};
    endfunction : word
    // cycles until the state moves; diagnostic toggles tallied meanwhile
    task automatic gap(output int c);
        logic [2:0] s;
        logic       d;
        s = st;
        c = 0;
        while (st === s && c < 20000)
        begin
            d = diag;
            cyc(1);
            c++;
            tg += int'(diag !== d);
        end
        if (c >= 20000)
        begin
            fail_count++;
            give_verdict();
        end
    endtask : gap
    initial
    begin
        cyc(4);
        rst_n = 1;
        cyc(2);
        check(drv, 0);
        send(word(1, 0, 0, commutation_pkg::DIAG_ZERO));
        check(drv, 8'h24);
        check({pa, pb, pc}, 3'b110);
        tg = 0;
        repeat (10) gap(g);
        check(g > 4350 && g < 4450, 1);
        check(tg > 6, 1);
        $display("test run done");
        stall = 1;
        repeat (3) gap(g);
        check(g > WL - 10 && g < WL + 10, 1);
        $display("test stall done");
        stall = 0;
        send(word(1, 1, 0, commutation_pkg::DIAG_THERMAL));
        repeat (2) gap(g);
        check(g > SL - 10 && g < SL + 10, 1);
        therm = 1;
        cyc(3);
        check(diag, 1);
        $display("test step done");
        send(word(1, 0, 1, commutation_pkg::DIAG_REV_PULSE));
        check(drv, 8'h15);
        rst_n = 0;
        cyc(4);
        rst_n = 1;
        cyc(2);
        check(drv, 0);
        send(word(1, 0, 0, commutation_pkg::DIAG_REV_PULSE));
        brk_n = 0;
        cyc(3);
        brk_n = 1;
        cyc(20);
        check(drv, 8'h15);
        $display("test brake done");
        // sector pulse as rev_pulse source; sync stands for the programmed 16 counts
        send(word(0, 0, 0, commutation_pkg::DIAG_SYNC) | 24'h0fffc0);
        sec = 1;
        cyc(4);
        check(diag, 1);
        sec = 0;
        cyc(20);
        check(diag, 0);
        $display("test sector done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
